// ===== rtl/pic_codec.sv
// Protection element encoder and decoder with an APB register file and an
// outgoing byte stream. Assumes pclk-synchronous APB and a same-clock sink.
// Notes on behaviour
// [RL1] Element identifiers are 0x50 sequence, 0x51 physical, 0x52 reject, 0x53 error; others reserved.
// [RL2] The logical channel number is 16-bit binary and every value 0 to 65535 is valid.
// [RL3] A provisioned list of at most 44 logical channel numbers is kept per interface.
// [RL4] The logical channel element is two octets, upper byte first.
// [RL5] Reset command and acknowledge messages carry an all-zero logical channel number.
// [RL6] The sequence element is identifier, length, then extension bit one over a 7-bit number.
// [RL7] The sequence number is 7-bit binary from 0 to 127.
// [RL8] A received sequence number equal to the last one marks a duplicate from the other link.
// [RL9] The physical channel element is identifier, length, link octet, slot octet.
// [RL10] The link identifier is a full 8-bit number selecting one of 256 links.
// [RL11] The slot number sits in the low five bits with the top three bits zero.
// [RL12] The exchange side only names time slots provisioned as physical channels.
// [RL13] The rejection cause element is exactly three octets.
// [RL14] Cause types 0 to 6 are defined and all others reserved.
// [RL15] Cause 0 is only sent by the exchange side towards the access-network side.
// [RL16] The cause octet carries an extension bit one over the 7-bit cause type.
// [RL17] Reserved identifiers, reserved causes and wrong length octets raise a decode error.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Byte FIFO
// ----------------------------------------------------------------
module pic_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("pic_fifo: DEPTH must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem      [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	always_comb begin
		in_ready    = (count != (AW + 1)'(DEPTH));
		out_valid   = (count != '0);
		out_data    = mem[rd_ptr];
		push        = in_valid && in_ready;
		pop         = out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count  = count + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	// Storage has no reset; empty slots are never presented as valid.
	always_ff @(posedge pclk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule

// ----------------------------------------------------------------
// Codec top
// ----------------------------------------------------------------
module pic_codec #(
	parameter int LCH_DEPTH  = pic_pkg::LCH_MAX,
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [7:0]  tx_byte,
	output logic             tx_valid,
	input  wire logic        tx_ready
);
	import pic_pkg::*;

	initial begin
		if (LCH_DEPTH < 1 || LCH_DEPTH > LCH_MAX)
			$error("pic_codec: LCH_DEPTH must lie between 1 and 44");
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	logic        setup;
	logic        wr;
	logic        hit;
	logic [31:0] rd_val;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;

	logic        side_exch;
	logic [15:0] enc_arg;
	logic [31:0] slot_mask;
	logic [5:0]  lch_sel;
	logic [15:0] lch_id    [LCH_DEPTH];
	logic        lch_valid [LCH_DEPTH];
	logic [6:0]  status;
	logic [15:0] dec_lch;
	logic [6:0]  dec_seq;
	logic [7:0]  dec_link;
	logic [4:0]  dec_slot;
	logic [6:0]  dec_cause;
	logic [3:0]  dec_err;
	logic        lch_sel_ok;

	// Writes take effect at the access edge; the answer is prepared in setup.
	assign setup      = psel && !penable;
	assign wr         = psel && penable && pready && pwrite;
	assign lch_sel_ok = (32'(lch_sel) < LCH_DEPTH);

	always_comb begin
		hit    = 1'b1;
		rd_val = 32'h0000_0000;
		case (paddr)
			OFF_CTRL:      rd_val = {31'h0000_0000, side_exch};
			OFF_ENC_CMD:   rd_val = {31'h0000_0000, status[ST_ENC_BUSY]};
			OFF_ENC_ARG:   rd_val = {16'h0000, enc_arg};
			OFF_STATUS:    rd_val = {25'h000_0000, status};
			OFF_RX_BYTE:   rd_val = 32'h0000_0000;
			OFF_DEC_LCH:   rd_val = {16'h0000, dec_lch};
			OFF_DEC_FLD:   rd_val = {1'b0, dec_cause, 3'h0, dec_slot, dec_link, 1'b0, dec_seq};
			OFF_DEC_ERR:   rd_val = {28'h000_0000, dec_err};
			OFF_SLOT_MASK: rd_val = slot_mask;
			OFF_LCH_SEL:   rd_val = {26'h000_0000, lch_sel};
			OFF_LCH_ENTRY: rd_val = lch_sel_ok ? {15'h0000, lch_valid[lch_sel], lch_id[lch_sel]}
						: 32'h0000_0000;
			default: begin
				hit    = 1'b0;
				rd_val = 32'h0000_0000;
			end
		endcase
		next_pready  = setup;
		next_pslverr = setup && !hit;
		next_prdata  = (setup && !pwrite) ? rd_val : 32'h0000_0000;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers and provisioned channel list
	// ----------------------------------------------------------------
	logic        next_side_exch;
	logic [15:0] next_enc_arg;
	logic [31:0] next_slot_mask;
	logic [5:0]  next_lch_sel;
	logic        wr_entry;
	logic        seq_clr;
	logic        lch_next;
	logic        rx_wr;

	always_comb begin
		next_side_exch = side_exch;
		next_enc_arg   = enc_arg;
		next_slot_mask = slot_mask;
		next_lch_sel   = lch_sel;
		if (wr && paddr == OFF_CTRL)
			next_side_exch = pwdata[CTRL_EXCH];
		if (wr && paddr == OFF_ENC_ARG)
			next_enc_arg = pwdata[15:0];
		if (wr && paddr == OFF_SLOT_MASK)
			next_slot_mask = pwdata;
		if (wr && paddr == OFF_LCH_SEL)
			next_lch_sel = pwdata[5:0];
		wr_entry = wr && paddr == OFF_LCH_ENTRY && lch_sel_ok;
		seq_clr  = wr && paddr == OFF_CTRL && pwdata[CTRL_SEQ_CLR];
		lch_next = wr && paddr == OFF_CTRL && pwdata[CTRL_LCH_NEXT];
		rx_wr    = wr && paddr == OFF_RX_BYTE;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			side_exch <= 1'b0;
			enc_arg   <= 16'h0000;
			slot_mask <= RST_SLOT_MASK;
			lch_sel   <= 6'h00;
		end else begin
			side_exch <= next_side_exch;
			enc_arg   <= next_enc_arg;
			slot_mask <= next_slot_mask;
			lch_sel   <= next_lch_sel;
		end
	end

	// The list holds at most 44 entries; any 16-bit number may be stored. [RL3] [RL2]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < LCH_DEPTH; i++) begin
				lch_id[i]    <= 16'h0000;
				lch_valid[i] <= 1'b0;
			end
		end else if (wr_entry) begin
			lch_id[lch_sel]    <= pwdata[15:0];
			lch_valid[lch_sel] <= pwdata[ENTRY_VALID];
		end
	end

	// ----------------------------------------------------------------
	// Encoder
	// ----------------------------------------------------------------
	logic [31:0] enc_buf;
	logic [2:0]  enc_left;
	logic [31:0] next_enc_buf;
	logic [2:0]  next_enc_left;
	logic        cmd_wr;
	logic        refuse;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [7:0]  fifo_out_data;
	logic        fifo_pop;
	pic_kind_t   cmd_kind;

	always_comb begin
		cmd_wr        = wr && paddr == OFF_ENC_CMD;
		cmd_kind      = pic_kind_t'(pwdata[1:0]);
		refuse        = 1'b0;
		next_enc_buf  = enc_buf;
		next_enc_left = enc_left;
		if (enc_left != 3'h0 && fifo_in_ready) begin
			next_enc_buf  = {enc_buf[23:0], 8'h00};
			next_enc_left = enc_left - 3'h1;
		end
		if (cmd_wr) begin
			if (enc_left != 3'h0) begin
				refuse = 1'b1;
			end else begin
				case (cmd_kind)
					K_LCH: begin
						// Upper octet goes first; reset messages send zero. [RL4] [RL5]
						next_enc_buf  = pwdata[CMD_RESET_MSG] ? 32'h0000_0000
								: {enc_arg, 16'h0000};
						next_enc_left = 3'h2;
					end
					K_SEQ: begin
						next_enc_buf  = {ID_SEQ, LEN_SEQ, 1'b1, enc_arg[6:0], 8'h00}; // [RL6] [RL7] [RL1]
						next_enc_left = 3'h3;
					end
					K_PHYS: begin
						// An exchange may only name provisioned slots. [RL12]
						if (side_exch && !slot_mask[enc_arg[4:0]]) begin
							refuse = 1'b1;
						end else begin
							next_enc_buf  = {ID_PHYS, LEN_PHYS, enc_arg[15:8],
									3'b000, enc_arg[4:0]}; // [RL9] [RL10] [RL11]
							next_enc_left = 3'h4;
						end
					end
					K_REJECT: begin
						// Reserved causes and cause 0 from the access side are refused. [RL14] [RL15]
						if (enc_arg[6:0] > CAUSE_MAX ||
								(enc_arg[6:0] == CAUSE_NO_STBY && !side_exch)) begin
							refuse = 1'b1;
						end else begin
							next_enc_buf  = {ID_REJECT, LEN_REJECT, 1'b1, enc_arg[6:0],
									8'h00}; // [RL13] [RL16]
							next_enc_left = 3'h3;
						end
					end
					default: refuse = 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enc_buf  <= 32'h0000_0000;
			enc_left <= 3'h0;
		end else begin
			enc_buf  <= next_enc_buf;
			enc_left <= next_enc_left;
		end
	end

	// The encoder stalls while the FIFO is full, so a slow sink holds it back.
	pic_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (enc_left != 3'h0),
		.in_ready  (fifo_in_ready),
		.in_data   (enc_buf[31:24]),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	// Output stage keeps tx_byte and tx_valid on flip-flops.
	logic       next_tx_valid;
	logic [7:0] next_tx_byte;

	always_comb begin
		fifo_pop      = fifo_out_valid && (!tx_valid || tx_ready);
		next_tx_valid = tx_valid && !tx_ready;
		next_tx_byte  = tx_byte;
		if (fifo_pop) begin
			next_tx_valid = 1'b1;
			next_tx_byte  = fifo_out_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_valid <= 1'b0;
			tx_byte  <= 8'h00;
		end else begin
			tx_valid <= next_tx_valid;
			tx_byte  <= next_tx_byte;
		end
	end

	// ----------------------------------------------------------------
	// Decoder, fed one byte per write of the receive register
	// ----------------------------------------------------------------
	typedef enum {D_ID, D_LEN, D_BODY, D_LHI, D_LLO} pic_dec_t;
	pic_dec_t   dec_state;
	pic_dec_t   next_dec_state;
	logic [7:0] dec_id;
	logic [7:0] next_dec_id;
	logic [1:0] dec_left;
	logic [1:0] next_dec_left;
	logic [7:0] rb;
	logic [6:0] last_seq;
	logic       last_seq_ok;
	logic [6:0] next_last_seq;
	logic       next_last_seq_ok;
	logic [15:0] next_dec_lch;
	logic [6:0] next_dec_seq;
	logic [7:0] next_dec_link;
	logic [4:0] next_dec_slot;
	logic [6:0] next_dec_cause;
	logic [3:0] next_dec_err;
	logic       ev_done;
	logic       ev_dup;
	logic       ev_unknown;
	logic       known;

	always_comb begin
		rb               = pwdata[7:0];
		next_dec_state   = dec_state;
		next_dec_id      = dec_id;
		next_dec_left    = dec_left;
		next_last_seq    = last_seq;
		next_last_seq_ok = last_seq_ok && !seq_clr;
		next_dec_lch     = dec_lch;
		next_dec_seq     = dec_seq;
		next_dec_link    = dec_link;
		next_dec_slot    = dec_slot;
		next_dec_cause   = dec_cause;
		next_dec_err     = ERR_NONE;
		ev_done          = 1'b0;
		ev_dup           = 1'b0;
		ev_unknown       = 1'b0;
		known            = 1'b0;
		for (int i = 0; i < LCH_DEPTH; i++)
			if (lch_valid[i] && lch_id[i] == {dec_lch[15:8], rb})
				known = 1'b1;
		if (lch_next)
			next_dec_state = D_LHI;
		else if (rx_wr) begin
			case (dec_state)
				D_ID: begin
					next_dec_id = rb;
					if (rb >= ID_SEQ && rb <= ID_PERR)
						next_dec_state = D_LEN;
					else
						next_dec_err = ERR_RSV_ID; // [RL1] [RL17]
				end
				D_LEN: begin
					next_dec_state = D_BODY;
					next_dec_left  = rb[1:0];
					// Length octets must match each element's fixed length, or lie from 1 to 3 for the error element. [RL17] [RL13]
					if ((dec_id == ID_SEQ && rb != LEN_SEQ) ||
							(dec_id == ID_PHYS && rb != LEN_PHYS) ||
							(dec_id == ID_REJECT && rb != LEN_REJECT) ||
							(dec_id == ID_PERR && (rb < LEN_PERR_MIN || rb > LEN_PERR_MAX))) begin
						next_dec_err   = ERR_LENGTH;
						next_dec_state = D_ID;
					end
				end
				D_BODY: begin
					next_dec_left = dec_left - 2'h1;
					if (dec_left == 2'h1) begin
						next_dec_state = D_ID;
						ev_done        = 1'b1;
					end
					case (dec_id)
						ID_SEQ: begin
							if (!rb[7]) begin
								next_dec_err = ERR_EXT; // [RL6]
								ev_done      = 1'b0;
							end else begin
								next_dec_seq     = rb[6:0]; // [RL7]
								ev_dup           = last_seq_ok && last_seq == rb[6:0]; // [RL8]
								next_last_seq    = rb[6:0];
								next_last_seq_ok = 1'b1;
							end
						end
						ID_PHYS: begin
							if (dec_left == 2'h2)
								next_dec_link = rb; // [RL10]
							else if (rb[7:5] != 3'b000) begin
								next_dec_err = ERR_SLOT; // [RL11]
								ev_done      = 1'b0;
							end else
								next_dec_slot = rb[4:0]; // [RL9]
						end
						ID_REJECT: begin
							next_dec_cause = rb[6:0];
							if (!rb[7]) begin
								next_dec_err = ERR_EXT; // [RL16]
								ev_done      = 1'b0;
							end else if (rb[6:0] > CAUSE_MAX) begin
								next_dec_err = ERR_CAUSE; // [RL14] [RL17]
								ev_done      = 1'b0;
							end else if (rb[6:0] == CAUSE_NO_STBY && side_exch) begin
								next_dec_err = ERR_DIR; // [RL15]
								ev_done      = 1'b0;
							end
						end
						default: ;
					endcase
				end
				D_LHI: begin
					next_dec_lch   = {rb, 8'h00}; // [RL4]
					next_dec_state = D_LLO;
				end
				D_LLO: begin
					next_dec_lch   = {dec_lch[15:8], rb};
					next_dec_state = D_ID;
					ev_done        = 1'b1;
					ev_unknown     = !known && ({dec_lch[15:8], rb} != 16'h0000); // [RL3] [RL5]
				end
				default: next_dec_state = D_ID;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_state   <= D_ID;
			dec_id      <= 8'h00;
			dec_left    <= 2'h0;
			last_seq    <= 7'h00;
			last_seq_ok <= 1'b0;
			dec_lch     <= 16'h0000;
			dec_seq     <= 7'h00;
			dec_link    <= 8'h00;
			dec_slot    <= 5'h00;
			dec_cause   <= 7'h00;
			dec_err     <= ERR_NONE;
		end else begin
			dec_state   <= next_dec_state;
			dec_id      <= next_dec_id;
			dec_left    <= next_dec_left;
			last_seq    <= next_last_seq;
			last_seq_ok <= next_last_seq_ok;
			dec_lch     <= next_dec_lch;
			dec_seq     <= next_dec_seq;
			dec_link    <= next_dec_link;
			dec_slot    <= next_dec_slot;
			dec_cause   <= next_dec_cause;
			dec_err     <= (next_dec_err != ERR_NONE) ? next_dec_err : dec_err;
		end
	end

	// ----------------------------------------------------------------
	// Status: sticky bits are write-one-to-clear, and a new event wins.
	// ----------------------------------------------------------------
	logic [6:0] next_status;
	logic [6:0] clr;

	always_comb begin
		clr         = (wr && paddr == OFF_STATUS) ? pwdata[6:0] : 7'h00;
		next_status = status & ~clr;
		next_status[ST_ENC_BUSY] = (next_enc_left != 3'h0);
		next_status[ST_TX_FULL]  = !fifo_in_ready;
		if (refuse)
			next_status[ST_ENC_REFUSED] = 1'b1;
		if (ev_done)
			next_status[ST_DEC_DONE] = 1'b1;
		if (next_dec_err != ERR_NONE)
			next_status[ST_DEC_ERR] = 1'b1;
		if (ev_done && dec_id == ID_SEQ && dec_state == D_BODY)
			next_status[ST_DUP] = ev_dup;
		if (ev_unknown)
			next_status[ST_LCH_UNKNOWN] = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status <= 7'h00;
		else
			status <= next_status;
	end
endmodule

// ===== rtl/pic_pkg.sv
// Constants shared by the protection element codec: register map, field
// positions, element identifiers and codes. Assumes a 32-bit APB master.
package pic_pkg;
	// ----------------------------------------------------------------
	// Element identifiers and fixed content lengths
	// ----------------------------------------------------------------
	localparam logic [7:0] ID_SEQ        = 8'h50;
	localparam logic [7:0] ID_PHYS       = 8'h51;
	localparam logic [7:0] ID_REJECT     = 8'h52;
	localparam logic [7:0] ID_PERR       = 8'h53;
	localparam logic [7:0] LEN_SEQ       = 8'h01;
	localparam logic [7:0] LEN_PHYS      = 8'h02;
	localparam logic [7:0] LEN_REJECT    = 8'h01;
	localparam logic [7:0] LEN_PERR_MIN  = 8'h01;
	localparam logic [7:0] LEN_PERR_MAX  = 8'h03;
	localparam logic [6:0] CAUSE_NO_STBY = 7'h00;
	localparam logic [6:0] CAUSE_MAX     = 7'h06;
	localparam int         LCH_MAX       = 44;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_ENC_CMD   = 8'h04;
	localparam logic [7:0] OFF_ENC_ARG   = 8'h08;
	localparam logic [7:0] OFF_STATUS    = 8'h0c;
	localparam logic [7:0] OFF_RX_BYTE   = 8'h10;
	localparam logic [7:0] OFF_DEC_LCH   = 8'h14;
	localparam logic [7:0] OFF_DEC_FLD   = 8'h18;
	localparam logic [7:0] OFF_DEC_ERR   = 8'h1c;
	localparam logic [7:0] OFF_SLOT_MASK = 8'h20;
	localparam logic [7:0] OFF_LCH_SEL   = 8'h24;
	localparam logic [7:0] OFF_LCH_ENTRY = 8'h28;
	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_EXCH      = 0;
	localparam int CTRL_SEQ_CLR   = 1;
	localparam int CTRL_LCH_NEXT  = 2;
	localparam int CMD_RESET_MSG  = 2;
	localparam int ST_ENC_BUSY    = 0;
	localparam int ST_ENC_REFUSED = 1;
	localparam int ST_DEC_DONE    = 2;
	localparam int ST_DEC_ERR     = 3;
	localparam int ST_DUP         = 4;
	localparam int ST_LCH_UNKNOWN = 5;
	localparam int ST_TX_FULL     = 6;
	localparam int ENTRY_VALID    = 16;
	localparam logic [31:0] RST_SLOT_MASK = 32'h0000_0000;
	// ----------------------------------------------------------------
	// Element kinds and decoder error codes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {K_LCH, K_SEQ, K_PHYS, K_REJECT} pic_kind_t;
	localparam logic [3:0] ERR_NONE     = 4'h0;
	localparam logic [3:0] ERR_RSV_ID   = 4'h1;
	localparam logic [3:0] ERR_LENGTH   = 4'h2;
	localparam logic [3:0] ERR_CAUSE    = 4'h3;
	localparam logic [3:0] ERR_EXT      = 4'h4;
	localparam logic [3:0] ERR_SLOT     = 4'h5;
	localparam logic [3:0] ERR_DIR      = 4'h6;
endpackage

// ===== verification/pic_chk.sv
// Concurrent checks on the codec's APB and outgoing byte stream ports.
// Assumes it is bound onto every pic_codec instance.
`timescale 1ns/1ps
module pic_chk
	import pic_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  tx_byte,
	input wire logic        tx_valid,
	input wire logic        tx_ready
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	setup_ready_a: assert property (psel && !penable |=> pready && psel && penable)
		else $error("no answer after setup");
	ready_once_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
		else $error("byte dropped while stalled");
	reset_quiet_a: assert property ($rose(presetn) |-> !tx_valid && !pready && !pslverr)
		else $error("outputs busy after reset");
	idle_data_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	unmapped_err_a: assert property (pready && paddr > OFF_LCH_ENTRY |-> pslverr && prdata == 0)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (pready && paddr <= OFF_LCH_ENTRY && paddr[1:0] == 2'b00
		|-> !pslverr)
		else $error("mapped access refused");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule

bind pic_codec pic_chk i_pic_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .tx_byte(tx_byte), .tx_valid(tx_valid),
	.tx_ready(tx_ready));

// ===== verification/pic_sink.sv
// Receive side of the peer entity, taking element bytes off the codec.
// Assumes the codec's same-clock valid and ready stream.
`timescale 1ns/1ps
module pic_sink (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic [1:0] mode,
	output logic           tx_ready
);
	logic [1:0] cnt;

	// Mode 0 takes every byte, mode 1 one in three cycles, mode 2 stalls for good.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt      <= 2'h0;
			tx_ready <= 1'b0;
		end else begin
			cnt      <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
			tx_ready <= (mode == 2'h0) || (mode == 2'h1 && cnt == 2'h2);
		end
	end
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the protection element codec.
// Assumes pic_codec, pic_sink and the bound checker are compiled before it.
`timescale 1ns/1ps
module testbench;
	import pic_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_valid, tx_ready;
	logic [7:0]  paddr, tx_byte;
	logic [31:0] pwdata, prdata, rdat, v;
	logic [1:0]  mode;
	logic [7:0]  exp_q[$];
	int          err_count, num_checks, cycles, seed, i;

	pic_codec i_pic_codec (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready));
	pic_sink i_pic_sink (.pclk(pclk), .presetn(presetn), .mode(mode), .tx_ready(tx_ready));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			stop_test();
		end
	end

	// Every byte the sink takes must be the oldest one noted by the driver.
	always @(posedge pclk) begin
		if (presetn && tx_valid && tx_ready) begin
			if (exp_q.size() == 0)
				check("spare byte", 32'h0, {24'h0, tx_byte});
			else
				check("tx byte", {24'h0, exp_q.pop_front()}, {24'h0, tx_byte});
		end
	end

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		check("pslverr", {31'h0, a > OFF_LCH_ENTRY}, {31'h0, pslverr});
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		check($sformatf("register %h", a), e, rdat & m);
	endtask

	task automatic push(input logic [31:0] b, input int n);
		for (int k = n - 1; k >= 0; k--) exp_q.push_back(b[8*k +: 8]);
	endtask

	task automatic rx(input logic [31:0] b, input int n);
		for (int k = n - 1; k >= 0; k--) xfer(1'b1, OFF_RX_BYTE, {24'h0, b[8*k +: 8]});
	endtask

	task automatic wait_idle;
		do xfer(1'b0, OFF_STATUS, 32'h0); while (rdat[ST_ENC_BUSY] !== 1'b0);
	endtask

	task automatic enc(input logic [2:0] c, input logic [15:0] a);
		xfer(1'b1, OFF_ENC_ARG, {16'h0, a});
		xfer(1'b1, OFF_ENC_CMD, {29'h0, c});
		wait_idle();
	endtask

	task automatic refused(input logic [2:0] c, input logic [15:0] a);
		enc(c, a);
		rd(OFF_STATUS, 32'h2, 32'h2);
		xfer(1'b1, OFF_STATUS, 32'h2);
	endtask

	initial begin
		seed = 32'hca85e4b1;
		{psel, penable, pwrite, paddr, pwdata, mode} = '0;
		presetn = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFF_CTRL, 32'hffffffff, 32'h0);
		rd(OFF_SLOT_MASK, 32'hffffffff, RST_SLOT_MASK);
		rd(OFF_STATUS, 32'hffffffff, 32'h0);
		rd(8'h40, 32'hffffffff, 32'h0);
		v = $random(seed);
		push(v[15:0], 2);
		enc(3'h0, v[15:0]);
		push(32'h0, 2);
		enc(3'h4, 16'hffff);
		for (i = 0; i < 3; i++) begin
			v = (i == 0) ? 32'h0 : (i == 1) ? 32'h7f : $random(seed) & 32'h7f;
			push({8'h50, 8'h01, 1'b1, v[6:0]}, 3);
			enc(3'h1, v[15:0]);
		end
		push(32'h5102ff1f, 4);
		enc(3'h2, 16'hff1f);
		xfer(1'b1, OFF_CTRL, 32'h1);
		refused(3'h2, 16'h0307);
		xfer(1'b1, OFF_SLOT_MASK, 32'h80);
		push(32'h51020307, 4);
		enc(3'h2, 16'h0307);
		push(32'h520180, 3);
		enc(3'h3, 16'h0);
		rx(32'h520180, 3);
		rd(OFF_DEC_ERR, 32'hf, {28'h0, ERR_DIR});
		xfer(1'b1, OFF_CTRL, 32'h0);
		refused(3'h3, 16'h0);
		refused(3'h3, 16'h7);
		for (i = 1; i < 7; i++) begin
			push({8'h52, 8'h01, 1'b1, i[6:0]}, 3);
			enc(3'h3, i[15:0]);
		end
		xfer(1'b1, OFF_STATUS, 32'hff);
		rx(32'h500185, 3);
		rd(OFF_DEC_FLD, 32'h7f, 32'h5);
		rd(OFF_STATUS, 32'h1c, 32'h4);
		rx(32'h500185, 3);
		rd(OFF_STATUS, 32'h10, 32'h10);
		rx(32'h54, 1);
		rd(OFF_DEC_ERR, 32'hf, {28'h0, ERR_RSV_ID});
		rx(32'h5202, 2);
		rd(OFF_DEC_ERR, 32'hf, {28'h0, ERR_LENGTH});
		rd(OFF_STATUS, 32'h8, 32'h8);
		xfer(1'b1, OFF_LCH_SEL, 32'd43);
		xfer(1'b1, OFF_LCH_ENTRY, 32'h1abcd);
		rd(OFF_LCH_ENTRY, 32'h1ffff, 32'h1abcd);
		xfer(1'b1, OFF_LCH_SEL, 32'd44);
		xfer(1'b1, OFF_LCH_ENTRY, 32'h1abcd);
		rd(OFF_LCH_ENTRY, 32'hffffffff, 32'h0);
		xfer(1'b1, OFF_CTRL, 32'h4);
		rx(32'habcd, 2);
		rd(OFF_DEC_LCH, 32'hffff, 32'habcd);
		rd(OFF_STATUS, 32'h20, 32'h0);
		xfer(1'b1, OFF_CTRL, 32'h4);
		rx(32'h0, 2);
		rd(OFF_STATUS, 32'h20, 32'h0);
		xfer(1'b1, OFF_CTRL, 32'h4);
		rx(32'h1234, 2);
		rd(OFF_STATUS, 32'h20, 32'h20);
		rx(32'h51020a05, 4);
		rd(OFF_DEC_FLD, 32'h1fff00, 32'h50a00);
		xfer(1'b1, OFF_CTRL, 32'h2);
		rx(32'h500185, 3);
		rd(OFF_STATUS, 32'h10, 32'h0);
		rx(32'h520187, 3);
		rd(OFF_DEC_ERR, 32'hf, {28'h0, ERR_CAUSE});
		rx(32'h520101, 3);
		rd(OFF_DEC_ERR, 32'hf, {28'h0, ERR_EXT});
		// Stall the sink so the byte buffer fills and the encoder has to wait.
		mode <= 2'h2;
		for (i = 0; i < 5; i++) begin
			push({8'h51, 8'h02, i[7:0], 8'h07}, 4);
			xfer(1'b1, OFF_ENC_ARG, {16'h0, i[7:0], 8'h07});
			xfer(1'b1, OFF_ENC_CMD, 32'h2);
			if (i < 4)
				wait_idle();
		end
		// The full flag is registered one edge after the buffer takes its last byte.
		@(posedge pclk);
		rd(OFF_STATUS, 32'h41, 32'h41);
		mode <= 2'h1;
		wait_idle();
		repeat (80) @(posedge pclk);
		check("bytes left", 32'h0, exp_q.size());
		stop_test();
	end
endmodule
